// file: logic/phase_ctrl_pkg.sv
// constants and types for the voltage-select decode and phase control block
package phase_ctrl_pkg;
  // apb register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] DUTY_OFF = 8'h04;
  localparam logic [7:0] ILIM_OFF = 8'h08;
  localparam logic [7:0] STATUS_OFF = 8'h0c;
  // control register fields
  localparam int CTRL_RUN_BIT = 0;
  // status register fields
  localparam int ST_CODE_LSB = 0;
  localparam int ST_SAVE_BIT = 8;
  localparam int ST_AUTO_BIT = 9;
  localparam int ST_PHASE_LSB = 10;
  localparam int ST_OFF_BIT = 13;
  // reset values
  localparam logic CTRL_RUN_RST = 1'b0;
  localparam logic [7:0] DUTY_RST = 8'h80;
  localparam logic [15:0] ILIM_RST = 16'h0100;
  // voltage-select code: 1.6125 V top, 6.25 mV per step
  localparam logic [8:0] REF_TOP_STEPS = 9'h102;
  localparam logic [7:0] CODE_LOWEST = 8'hb2;
  localparam logic [7:0] CODE_OFF_A = 8'hfe;
  localparam logic [7:0] CODE_OFF_B = 8'hff;
  // pwm timing: one counter step every PWM_DIV clocks
  localparam int PWM_DIV = 4;
  localparam logic [1:0] PWM_DIV_LAST = 2'(PWM_DIV - 1);
  // phase slot offsets inside the 256-step pwm period
  localparam logic [7:0] OFS_HALF = 8'h80;
  localparam logic [7:0] OFS_THIRD = 8'h55;
  localparam logic [7:0] OFS_TWO_THIRD = 8'hab;
  localparam logic [7:0] OFS_QUARTER = 8'h40;
  localparam logic [7:0] OFS_3QUARTER = 8'hc0;
  // phase counts
  localparam logic [2:0] PH_TWO = 3'h2;
  localparam logic [2:0] PH_THREE = 3'h3;
  localparam logic [2:0] PH_FOUR = 3'h4;
  localparam logic [3:0] MASK_TWO = 4'h5;
  localparam logic [3:0] MASK_THREE = 4'h7;
  localparam logic [3:0] MASK_FOUR = 4'hf;

  typedef enum logic [1:0] {
    AUTO_NORMAL = 2'b01,
    AUTO_SAVE = 2'b10
  } auto_state_t;
endpackage : phase_ctrl_pkg

// file: logic/phase_ctrl.sv
// voltage-select decode, power-save decision and phase shedding with apb
`timescale 1ns/100ps

module phase_ctrl
  import phase_ctrl_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // processor side
  input wire logic [7:0] voltage_select_code,
  input wire logic forced_power_save_request_n,
  input wire logic auto_save_enable,
  // gate pwm pins, bit 0 is gate_pwm_out_1
  input wire logic [3:0] gate_pwm_out_in,
  output logic [3:0] gate_pwm_out_o,
  output logic [3:0] gate_pwm_out_oe,
  // analog-facing results
  output logic [8:0] reference_steps,
  output logic regulate_en,
  output logic [15:0] current_limit,
  output logic power_save,
  output logic [2:0] active_phases
);

  function automatic logic code_is_off(input logic [7:0] c);
    code_is_off = (c == CODE_OFF_A) || (c == CODE_OFF_B);
  endfunction : code_is_off

  function automatic logic code_is_valid(input logic [7:0] c);
    code_is_valid = (c <= CODE_LOWEST);
  endfunction : code_is_valid

  function automatic logic [15:0] split_limit(input logic [15:0] lim,
                                              input logic [2:0] n);
    case (n)
      PH_TWO: split_limit = lim >> 1;
      PH_THREE: split_limit = 16'(lim / 16'h0003);
      default: split_limit = lim >> 2;
    endcase
  endfunction : split_limit

  // ---------------- apb registers
  logic run_r, run_nxt;
  logic [7:0] duty_r, duty_nxt;
  logic [15:0] ilim_r, ilim_nxt;
  logic [31:0] prdata_nxt;
  logic wr_en, rd_setup, addr_ok;
  logic [31:0] status_word;
  logic auto_save_r;

  // phase strap
  logic strap_done_r, strap_done_nxt;
  logic [2:0] phases_r, phases_nxt;
  logic [3:0] mask_r, mask_nxt;

  assign pready = 1'b1;
  assign addr_ok = (paddr == CTRL_OFF) || (paddr == DUTY_OFF)
                || (paddr == ILIM_OFF) || (paddr == STATUS_OFF);
  assign pslverr = psel && penable && !addr_ok;
  assign wr_en = psel && penable && pwrite && addr_ok;
  assign rd_setup = psel && !penable && !pwrite;

  always_comb begin
    status_word = 32'h0;
    status_word[ST_CODE_LSB +: 8] = voltage_select_code;
    status_word[ST_SAVE_BIT] = power_save;
    status_word[ST_AUTO_BIT] = auto_save_r;
    status_word[ST_PHASE_LSB +: 3] = phases_r;
    status_word[ST_OFF_BIT] = !regulate_en;
  end

  always_comb begin
    run_nxt = run_r;
    duty_nxt = duty_r;
    ilim_nxt = ilim_r;
    prdata_nxt = prdata;
    if (wr_en) begin
      case (paddr)
        CTRL_OFF: run_nxt = pwdata[CTRL_RUN_BIT];
        DUTY_OFF: duty_nxt = pwdata[7:0];
        ILIM_OFF: ilim_nxt = pwdata[15:0];
        default: ;
      endcase
    end
    if (rd_setup) begin
      case (paddr)
        CTRL_OFF: prdata_nxt = {31'h0, run_r};
        DUTY_OFF: prdata_nxt = {24'h0, duty_r};
        ILIM_OFF: prdata_nxt = {16'h0, ilim_r};
        STATUS_OFF: prdata_nxt = status_word;
        default: prdata_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      run_r <= CTRL_RUN_RST;
      duty_r <= DUTY_RST;
      ilim_r <= ILIM_RST;
      prdata <= 32'h0;
    end else begin
      run_r <= run_nxt;
      duty_r <= duty_nxt;
      ilim_r <= ilim_nxt;
      prdata <= prdata_nxt;
    end
  end

  // ---------------- phase count from grounded gate pins
  // pins are sensed once, while not driven, on the first edge after reset
  always_comb begin
    strap_done_nxt = 1'b1;
    phases_nxt = phases_r;
    mask_nxt = mask_r;
    if (!strap_done_r) begin
      if (!gate_pwm_out_in[1] && !gate_pwm_out_in[3]) begin
        phases_nxt = PH_TWO;
        mask_nxt = MASK_TWO;
      end else if (!gate_pwm_out_in[3]) begin
        phases_nxt = PH_THREE;
        mask_nxt = MASK_THREE;
      end else begin
        phases_nxt = PH_FOUR;
        mask_nxt = MASK_FOUR;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      strap_done_r <= 1'b0;
      phases_r <= PH_FOUR;
      mask_r <= 4'h0;
    end else begin
      strap_done_r <= strap_done_nxt;
      phases_r <= phases_nxt;
      mask_r <= mask_nxt;
    end
  end

  // ---------------- code decode
  logic [7:0] prev_code_r, prev_code_nxt;
  logic [8:0] ref_nxt;
  logic regulate_nxt;
  logic volt_down, volt_up;

  always_comb begin
    ref_nxt = reference_steps;
    prev_code_nxt = prev_code_r;
    regulate_nxt = !code_is_off(voltage_select_code);
    // codes between the lowest setting and off are ignored
    if (code_is_valid(voltage_select_code)) begin
      ref_nxt = REF_TOP_STEPS - {1'b0, voltage_select_code};
      prev_code_nxt = voltage_select_code;
    end
  end

  // a larger code is a lower voltage
  assign volt_down = code_is_valid(voltage_select_code)
                  && (voltage_select_code > prev_code_r);
  assign volt_up = code_is_valid(voltage_select_code)
                && (voltage_select_code < prev_code_r);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reference_steps <= 9'h0;
      regulate_en <= 1'b0;
      prev_code_r <= 8'h0;
    end else begin
      reference_steps <= ref_nxt;
      regulate_en <= regulate_nxt;
      prev_code_r <= prev_code_nxt;
    end
  end

  // ---------------- power-save decision
  auto_state_t auto_r, auto_nxt;
  logic save_nxt;
  logic [15:0] limit_nxt;

  always_comb begin
    auto_nxt = auto_r;
    // tracking runs only while enabled, so re-enabling starts from normal
    if (!auto_save_enable) begin
      auto_nxt = AUTO_NORMAL;
    end else begin
      case (auto_r)
        AUTO_NORMAL: if (volt_down) auto_nxt = AUTO_SAVE;
        AUTO_SAVE: if (volt_up) auto_nxt = AUTO_NORMAL;
        default: auto_nxt = AUTO_NORMAL;
      endcase
    end
    save_nxt = !forced_power_save_request_n
            || (auto_save_enable && auto_r == AUTO_SAVE);
    limit_nxt = power_save ? split_limit(ilim_r, phases_r) : ilim_r;
  end

  assign auto_save_r = (auto_r == AUTO_SAVE);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      auto_r <= AUTO_NORMAL;
      power_save <= 1'b0;
      current_limit <= 16'h0;
    end else begin
      auto_r <= auto_nxt;
      power_save <= save_nxt;
      current_limit <= limit_nxt;
    end
  end

  // ---------------- pwm generation
  logic [1:0] div_r, div_nxt;
  logic [7:0] ramp_r, ramp_nxt;
  logic tick;
  logic [3:0] gate_nxt;
  logic [31:0] offs;
  logic [3:0] live;
  logic [2:0] act_nxt;

  assign tick = (div_r == PWM_DIV_LAST);

  always_comb begin
    div_nxt = tick ? 2'h0 : div_r + 2'h1;
    ramp_nxt = tick ? ramp_r + 8'h01 : ramp_r;
    case (phases_r)
      PH_TWO: offs = {8'h00, 8'h00, OFS_HALF, 8'h00};
      PH_THREE: offs = {8'h00, OFS_TWO_THIRD, OFS_THIRD, 8'h00};
      default: offs = {OFS_3QUARTER, OFS_HALF, OFS_QUARTER, 8'h00};
    endcase
    // two-phase uses slots of outputs one and three
    if (phases_r == PH_TWO) offs = {8'h00, OFS_HALF, 8'h00, 8'h00};
    live = power_save ? 4'h1 : mask_r;
    act_nxt = power_save ? 3'h1 : phases_r;
    for (int i = 0; i < 4; i++) begin
      gate_nxt[i] = live[i] && run_r && regulate_en && strap_done_r
                 && ((ramp_r + offs[8*i +: 8]) < duty_r);
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      div_r <= 2'h0;
      ramp_r <= 8'h0;
      gate_pwm_out_o <= 4'h0;
      active_phases <= 3'h0;
    end else begin
      div_r <= div_nxt;
      ramp_r <= ramp_nxt;
      gate_pwm_out_o <= gate_nxt;
      active_phases <= act_nxt;
    end
  end

  // only outputs in the strapped phase mask are driven; only pins 2 and 4 are sensed
  assign gate_pwm_out_oe = mask_r;

  // ---------------- checks
  property p_off_stops;
    @(posedge clock) disable iff (sys_rst)
    code_is_off(voltage_select_code) |=>
      !regulate_en ##1 gate_pwm_out_o == 4'h0;
  endproperty
  a_off_stops: assert property (p_off_stops) else $error("off code regulates");

  property p_ref_map;
    @(posedge clock) disable iff (sys_rst)
    code_is_valid(voltage_select_code) |=>
      reference_steps == REF_TOP_STEPS - {1'b0, $past(voltage_select_code)};
  endproperty
  a_ref_map: assert property (p_ref_map) else $error("bad reference");

  property p_forced;
    @(posedge clock) disable iff (sys_rst)
    !forced_power_save_request_n |=> power_save;
  endproperty
  a_forced: assert property (p_forced) else $error("forced save ignored");

  property p_auto_enter;
    @(posedge clock) disable iff (sys_rst)
    auto_save_enable && forced_power_save_request_n && volt_down
      && $rose(auto_save_enable) == 1'b0 ##1 auto_save_enable
      |=> power_save;
  endproperty
  a_auto_enter: assert property (p_auto_enter) else $error("no auto entry");

  property p_auto_exit;
    @(posedge clock) disable iff (sys_rst)
    auto_save_r && auto_save_enable && volt_up ##1 forced_power_save_request_n
      |=> !power_save;
  endproperty
  a_auto_exit: assert property (p_auto_exit) else $error("no auto exit");

  property p_auto_off;
    @(posedge clock) disable iff (sys_rst)
    !auto_save_enable && forced_power_save_request_n |=> !power_save;
  endproperty
  a_auto_off: assert property (p_auto_off) else $error("save while disabled");

  property p_single;
    @(posedge clock) disable iff (sys_rst)
    power_save |=> gate_pwm_out_o[3:1] == 3'h0 && active_phases == 3'h1;
  endproperty
  a_single: assert property (p_single) else $error("extra phase in save");

  property p_limit;
    @(posedge clock) disable iff (sys_rst)
    power_save && phases_r == PH_FOUR |=> current_limit == $past(ilim_r) >> 2;
  endproperty
  a_limit: assert property (p_limit) else $error("limit not scaled");

  property p_two_phase;
    @(posedge clock) disable iff (sys_rst)
    strap_done_r && phases_r == PH_TWO |-> gate_pwm_out_oe == MASK_TWO;
  endproperty
  a_two_phase: assert property (p_two_phase) else $error("bad 2-phase pins");

  property p_three_phase;
    @(posedge clock) disable iff (sys_rst)
    strap_done_r && phases_r == PH_THREE |-> gate_pwm_out_oe == MASK_THREE;
  endproperty
  a_three_phase: assert property (p_three_phase) else $error("bad 3-phase pins");

  property p_four_phase;
    @(posedge clock) disable iff (sys_rst)
    strap_done_r && phases_r == PH_FOUR |-> gate_pwm_out_oe == MASK_FOUR;
  endproperty
  a_four_phase: assert property (p_four_phase) else $error("bad 4-phase pins");

endmodule : phase_ctrl

// file: verif/cpu_side_model.sv
// processor-side model: drives the code and save pins, straps gate pins
`timescale 1ns/100ps
module cpu_side_model (
  // clock
  input wire logic clock,
  // gate pins as seen on the board
  input wire logic [3:0] gnd_mask,
  input wire logic [3:0] gate_o,
  input wire logic [3:0] gate_oe,
  output logic [3:0] gate_in,
  // processor pins
  output logic [7:0] code,
  output logic forced_n,
  output logic enable
);
  initial begin
    code = 8'h20;
    forced_n = 1'b1;
    enable = 1'b0;
  end
  // unused gate pins are grounded, undriven used ones float to the pull-up
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      gate_in[i] = gate_oe[i] ? gate_o[i] : !gnd_mask[i];
    end
  end
  // pins change only just after an edge, like a synchronous processor
  task put(input logic [7:0] c, input logic f, input logic e);
    @(posedge clock);
    code <= c;
    forced_n <= f;
    enable <= e;
  endtask : put
endmodule : cpu_side_model

// file: verif/vid_decode_phase_shed_control_tb_top.sv
// self-checking bench for the voltage-select decode and phase control
`timescale 1ns/100ps
module vid_decode_phase_shed_control_tb_top;
  import phase_ctrl_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, forced_n, enable, regulate_en, power_save;
  logic [3:0] gnd_mask = 4'h0;
  logic [3:0] gate_in, gate_o, gate_oe;
  logic [7:0] code;
  logic [8:0] reference_steps;
  logic [15:0] current_limit;
  logic [2:0] active_phases;
  int fails = 0;
  int samples_checked = 0;
  logic [31:0] q;
  logic e;

  always #5 clock = ~clock;

  phase_ctrl u_phase_ctrl (.clock(clock), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .voltage_select_code(code), .forced_power_save_request_n(forced_n),
    .auto_save_enable(enable), .gate_pwm_out_in(gate_in),
    .gate_pwm_out_o(gate_o), .gate_pwm_out_oe(gate_oe),
    .reference_steps(reference_steps), .regulate_en(regulate_en),
    .current_limit(current_limit), .power_save(power_save),
    .active_phases(active_phases));

  cpu_side_model u_cpu_side_model (.clock(clock), .gnd_mask(gnd_mask),
    .gate_o(gate_o), .gate_oe(gate_oe), .gate_in(gate_in), .code(code),
    .forced_n(forced_n), .enable(enable));

  task wrap_up;
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up

  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    samples_checked++;
    if (g !== x) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask : chk

  // let n edges pass, then look where outputs have settled
  task settle(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask : settle

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      wrap_up();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task do_reset(input logic [3:0] m);
    @(posedge clock);
    gnd_mask <= m;
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    settle(3);
  endtask : do_reset

  task t_regs;
    apb(0, CTRL_OFF, 0); chk("ctrl", 0, q);
    apb(0, DUTY_OFF, 0); chk("duty", 32'h80, q);
    apb(0, ILIM_OFF, 0); chk("ilim", 32'h100, q);
    chk("err mapped", 0, 32'(e));
    apb(0, 8'h10, 0); chk("err unmapped", 1, 32'(e));
    apb(1, CTRL_OFF, 32'h1);
  endtask : t_regs

  task t_decode;
    logic [7:0] c [5] = '{8'h00, 8'h62, CODE_LOWEST, CODE_OFF_A, CODE_OFF_B};
    for (int i = 0; i < 5; i++) begin
      u_cpu_side_model.put(c[i], 1, 0);
      settle(2);
      chk("regulate", 32'(i < 3), 32'(regulate_en));
      if (i < 3) chk("ref", 32'(258 - c[i]), 32'(reference_steps));
    end
    u_cpu_side_model.put(8'h20, 1, 0);
    settle(3);
  endtask : t_decode

  task t_auto;
    apb(1, ILIM_OFF, 32'h200);
    u_cpu_side_model.put(8'h20, 1, 1);
    settle(3);
    u_cpu_side_model.put(8'h30, 1, 1);
    settle(5);
    chk("save on drop", 1, 32'(power_save));
    chk("phases", 1, 32'(active_phases));
    chk("oe save", 32'hf, 32'(gate_oe));
    chk("gates save", 0, 32'(gate_o[3:1]));
    chk("limit save", 32'h80, 32'(current_limit));
    apb(0, STATUS_OFF, 0);
    chk("status", 32'h1330, q);
    u_cpu_side_model.put(8'h20, 1, 1);
    settle(5);
    chk("save off rise", 0, 32'(power_save));
    chk("oe normal", 32'hf, 32'(gate_oe));
    chk("limit normal", 32'h200, 32'(current_limit));
  endtask : t_auto

  task t_gate;
    u_cpu_side_model.put(8'h40, 1, 0);
    settle(5);
    chk("auto gated", 0, 32'(power_save));
    u_cpu_side_model.put(8'h40, 0, 0);
    settle(4);
    chk("forced save", 1, 32'(power_save));
    u_cpu_side_model.put(8'h40, 1, 0);
    settle(4);
    chk("forced off", 0, 32'(power_save));
  endtask : t_gate

  task t_phases;
    logic [3:0] m [3] = '{4'ha, 4'h8, 4'h0};
    logic [3:0] oe [3] = '{MASK_TWO, MASK_THREE, MASK_FOUR};
    for (int i = 0; i < 3; i++) begin
      do_reset(m[i]);
      chk("count", 32'(i + 2), 32'(active_phases));
      chk("oe used", 32'(oe[i]), 32'(gate_oe));
      u_cpu_side_model.put(8'h20, 0, 0);
      settle(5);
      chk("limit", 32'(16'h0100 / (i + 2)), 32'(current_limit));
      chk("oe kept", 32'(oe[i]), 32'(gate_oe));
      chk("one phase", 1, 32'(active_phases));
      u_cpu_side_model.put(8'h20, 1, 0);
    end
  endtask : t_phases

  initial begin
    do_reset(4'h0);
    t_regs();
    t_decode();
    t_auto();
    t_gate();
    t_phases();
    wrap_up();
  end
endmodule : vid_decode_phase_shed_control_tb_top
